/* design/synth_post_divider_outputs.sv */
// Post-dividers A and B of synthesizer 0 with their configuration registers.
// Assumes synthesizer output and doubled base rate arrive as CLK-synchronous tick pulses
// and the sibling C and D clocks as CLK-synchronous levels.
// Sibling clocks are seen through one CLK sample, so pulse edges trail them by one cycle.
// A sibling faster than half of CLK cannot be followed.
//
// Functional notes
// - Mode not all ones: divide synth output by word.
// - Divider mode uses all 24 bits as ratio.
// - A: mode ones, source 00 gives low-frequency clock.
// - Otherwise mode ones gives one-period frame pulse.
// - Low sixteen bits count sibling periods between pulses.
// - Source pair picks sibling clock for pulse width.
// - B sources: A, low-frequency, C, D.
// - B low-frequency: twice base divided by low bits.
// - Bit 18 set makes pulse active low.
// - Bit 19 clear centres boundary in pulse.
// - Bit 19 set starts pulse at boundary.
// - Both words reset to 0x000002.
// - A sources: low-frequency, B, C, D.
`default_nettype none
module synth_post_divider_outputs
	import postdiv_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       SRST,
	input  wire logic       CE,
	input  wire logic       SYN_TICK,
	input  wire logic       BASE2_TICK,
	input  wire logic       CLK_C,
	input  wire logic       CLK_D,
	input  wire logic [6:0] REG_ADDR,
	input  wire logic [7:0] REG_WDATA,
	input  wire logic       REG_WR,
	output logic      [7:0] REG_RDATA,
	output logic            OUT_A,
	output logic            OUT_B
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic out_mode_t decode_mode(input div_cfg_t c, input logic [1:0] lf_src);
		if (c.mode != MODE_SPECIAL)
			return OUT_DIVIDER;
		else if (c.src == lf_src)
			return OUT_LOWFREQ;
		else
			return OUT_FRAME;
	endfunction

	// A zero or one ratio is treated as one, which holds a divider output low and a frame output at its active level.
	function automatic logic [23:0] wrap_count(input logic [23:0] cnt, input logic [23:0] n);
		return (cnt + 24'h000001 >= n) ? 24'h000000 : cnt + 24'h000001;
	endfunction

	// ----------------------------------------------------------------
	// Configuration port
	// ----------------------------------------------------------------
	logic                 page_r;
	div_cfg_t             cfg_r      [NUM_DIV];
	logic     [7:0]       shadow_r   [NUM_DIV][NUM_BYTES];
	logic     [2:0]       wmask_r    [NUM_DIV];
	logic     [NUM_DIV-1:0] commit;

	wire        page_hit  = (REG_ADDR == PAGE_REG_ADDR[6:0]);
	wire  [7:0] full_addr = {page_r & ~page_hit, REG_ADDR};
	wire  [7:0] off_a     = full_addr - DIV_A_ADDR;
	wire  [7:0] off_b     = full_addr - DIV_B_ADDR;
	wire        hit_a     = (off_a < 8'(NUM_BYTES));
	wire        hit_b     = (off_b < 8'(NUM_BYTES));
	wire  [1:0] sel_a     = off_a[1:0];
	wire  [1:0] sel_b     = off_b[1:0];
	wire [23:0] word_a    = cfg_r[0];
	wire [23:0] word_b    = cfg_r[1];
	wire  [7:0] rd_a      = word_a[8*sel_a +: 8];
	wire  [7:0] rd_b      = word_b[8*sel_b +: 8];
	wire  [7:0] rd_data   = page_hit ? {7'h00, page_r} :
		hit_a ? rd_a : hit_b ? rd_b : 8'h00;
	wire        wr_a      = REG_WR & hit_a & ~page_hit;
	wire        wr_b      = REG_WR & hit_b & ~page_hit;

	// Bytes collect in a shadow so the divider never runs on a half-written word.
	assign commit[0] = wr_a & ((wmask_r[0] | (3'h1 << sel_a)) == ALL_BYTES);
	assign commit[1] = wr_b & ((wmask_r[1] | (3'h1 << sel_b)) == ALL_BYTES);

	// ----------------------------------------------------------------
	// Per-divider write decode
	// ----------------------------------------------------------------
	// Indexed copies of the A and B decode keep the register loop uniform.
	logic [1:0] bsel   [NUM_DIV];
	logic       wr_sel [NUM_DIV];
	assign bsel[0]   = sel_a;
	assign bsel[1]   = sel_b;
	assign wr_sel[0] = wr_a;
	assign wr_sel[1] = wr_b;

	// Reads return the committed word, never the shadow bytes.

	always_ff @(posedge CLK) begin
		if (SRST) begin
			page_r    <= 1'b0;
			REG_RDATA <= 8'h00;
			for (int d = 0; d < NUM_DIV; d++) begin
				cfg_r[d]   <= DIV_CFG_RESET;
				wmask_r[d] <= 3'h0;
				for (int b = 0; b < NUM_BYTES; b++)
					shadow_r[d][b] <= DIV_CFG_RESET[8*b +: 8];
			end
		end else if (CE) begin
			REG_RDATA <= rd_data;
			if (REG_WR && page_hit)
				page_r <= REG_WDATA[0];
			for (int d = 0; d < NUM_DIV; d++) begin
				if (wr_sel[d]) begin
					shadow_r[d][bsel[d]] <= REG_WDATA;
					wmask_r[d] <= commit[d] ? 3'h0 :
						wmask_r[d] | (3'h1 << bsel[d]);
				end
				if (commit[d]) begin
					for (int b = 0; b < NUM_BYTES; b++)
						cfg_r[d][8*b +: 8] <= (b == bsel[d]) ?
							REG_WDATA : shadow_r[d][b];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Output generation
	// ----------------------------------------------------------------
	logic [23:0] cnt_r    [NUM_DIV];
	logic [23:0] cnt_nxt  [NUM_DIV];
	logic        out_r    [NUM_DIV];
	logic        out_nxt  [NUM_DIV];
	logic        prev_r   [NUM_DIV];
	logic        sib      [NUM_DIV];
	logic        gci_r    [NUM_DIV];
	logic        gci_nxt  [NUM_DIV];
	logic        st_r     [NUM_DIV];
	logic        st_nxt   [NUM_DIV];

	always_comb begin
		logic [1:0]  lf;
		logic [23:0] ratio;
		logic [23:0] half;
		logic [23:0] rate;
		logic        rise;
		logic        fall;
		out_mode_t   m;
		lf    = LF_SRC_A;
		ratio = 24'h000000;
		half  = 24'h000000;
		rate  = 24'h000000;
		rise  = 1'b0;
		fall  = 1'b0;
		m     = OUT_DIVIDER;
		for (int d = 0; d < NUM_DIV; d++) begin
			lf = (d == 0) ? LF_SRC_A : LF_SRC_B;
			m  = decode_mode(cfg_r[d], lf);
			// Sibling pick: C and D by code, the other post-divider otherwise.
			sib[d] = (cfg_r[d].src == SRC_C) ? CLK_C :
				(cfg_r[d].src == SRC_D) ? CLK_D : out_r[1-d];
			rise        = sib[d] & ~prev_r[d];
			fall        = ~sib[d] & prev_r[d];
			ratio       = (m == OUT_DIVIDER) ? cfg_r[d] : {8'h00, cfg_r[d].rate};
			half        = ratio >> 1;
			rate        = {8'h00, cfg_r[d].rate};
			cnt_nxt[d]  = cnt_r[d];
			gci_nxt[d]  = gci_r[d];
			st_nxt[d]   = st_r[d];
			out_nxt[d]  = out_r[d];
			case (m)
				OUT_DIVIDER, OUT_LOWFREQ: begin
					if ((m == OUT_DIVIDER) ? SYN_TICK : BASE2_TICK)
						cnt_nxt[d] = wrap_count(cnt_r[d], ratio);
					out_nxt[d] = (cnt_nxt[d] < half);
				end
				OUT_FRAME: begin
					if (rise) begin
						cnt_nxt[d] = wrap_count(cnt_r[d], rate);
						gci_nxt[d] = (cnt_nxt[d] == 24'h000000);
					end
					if (fall)
						st_nxt[d] = (cnt_r[d] + 24'h000001 >= rate);
					// Framing applies at once on commit, so the first pulse may be clipped.
					out_nxt[d] = cfg_r[d].polarity ^
						(cfg_r[d].frm_type ? gci_nxt[d] : st_nxt[d]);
				end
				default: out_nxt[d] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int d = 0; d < NUM_DIV; d++) begin
				cnt_r[d]  <= 24'h000000;
				out_r[d]  <= 1'b0;
				prev_r[d] <= 1'b0;
				gci_r[d]  <= 1'b0;
				st_r[d]   <= 1'b0;
			end
		end else if (CE) begin
			for (int d = 0; d < NUM_DIV; d++) begin
				// A fresh word restarts the count so the new ratio starts from a clean phase.
				cnt_r[d]  <= commit[d] ? 24'h000000 : cnt_nxt[d];
				out_r[d]  <= out_nxt[d];
				prev_r[d] <= sib[d];
				gci_r[d]  <= gci_nxt[d];
				st_r[d]   <= st_nxt[d];
			end
		end
	end

	// ----------------------------------------------------------------
	// Output ports
	// ----------------------------------------------------------------
	assign OUT_A = out_r[0];
	assign OUT_B = out_r[1];
endmodule // synth_post_divider_outputs
`default_nettype wire

/* design/postdiv_pkg.sv */
// Constants, field layout and mode types for the synthesizer 0 post-divider outputs A and B.
// Assumes a byte-wide configuration port with seven address bits and a page bit.
`default_nettype none
package postdiv_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  PAGE_REG_ADDR  = 8'h7f;
	localparam logic [7:0]  DIV_A_ADDR     = 8'h80;
	localparam logic [7:0]  DIV_B_ADDR     = 8'h83;
	localparam logic [23:0] DIV_CFG_RESET  = 24'h000002;
	localparam logic [3:0]  MODE_SPECIAL   = 4'hf;
	localparam logic [1:0]  LF_SRC_A       = 2'h0;
	localparam logic [1:0]  LF_SRC_B       = 2'h1;
	localparam logic [1:0]  SRC_C          = 2'h2;
	localparam logic [1:0]  SRC_D          = 2'h3;
	localparam logic [2:0]  ALL_BYTES      = 3'h7;
	localparam int          NUM_DIV        = 2;
	localparam int          NUM_BYTES      = 3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  mode;
		logic        frm_type;
		logic        polarity;
		logic [1:0]  src;
		logic [15:0] rate;
	} div_cfg_t;

	typedef enum logic [1:0] {
		OUT_DIVIDER = 2'b00,
		OUT_LOWFREQ = 2'b01,
		OUT_FRAME   = 2'b10
	} out_mode_t;
endpackage
`default_nettype wire

/* verif/postdiv_chk_sva.sv */
// Port checks for the post-divider block, bound to its top module.
// Assumes one clock domain and the divide-by-two reset setting.
`default_nettype none
module postdiv_chk (
	input wire logic       CLK,
	input wire logic       SRST,
	input wire logic       CE,
	input wire logic       SYN_TICK,
	input wire logic [6:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic       REG_WR,
	input wire logic [7:0] REG_RDATA,
	input wire logic       OUT_A,
	input wire logic       OUT_B
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----
	// Checks
	// ----
	// Any write ends the span in which both outputs must still match.
	logic wr_seen_r;
	always_ff @(posedge CLK) begin
		wr_seen_r <= !SRST && (wr_seen_r || (CE && REG_WR));
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	a_reset_clear: assert property ($fell(SRST) |-> !REG_RDATA && !OUT_A && !OUT_B)
		else $error("reset state wrong");
	a_page_upper: assert property (CE && !REG_WR && REG_ADDR == 7'h7f |=> !REG_RDATA[7:1])
		else $error("page upper bits set");
	a_page_write: assert property (CE && REG_WR && REG_ADDR == 7'h7f ##1
		CE && !REG_WR && REG_ADDR == 7'h7f |=> REG_RDATA[0] == $past(REG_WDATA[0], 2))
		else $error("page bit lost");
	a_unmapped_zero: assert property (CE && REG_ADDR inside {[7'h06:7'h7e]} |=> !REG_RDATA)
		else $error("unmapped read not zero");
	a_read_stable: assert property (CE && !REG_WR && $stable(REG_ADDR) && $past(CE)
		&& !$past(REG_WR) && !$past(SRST) |=> $stable(REG_RDATA))
		else $error("read data moved without write");
	a_default_pair: assert property (!wr_seen_r |-> OUT_A == OUT_B)
		else $error("outputs differ at reset setting");
	a_default_high_a: assert property (!wr_seen_r && CE && SYN_TICK && OUT_A |=> !OUT_A)
		else $error("output A high too long");
	a_default_high_b: assert property (!wr_seen_r && CE && SYN_TICK && OUT_B |=> !OUT_B)
		else $error("output B high too long");
endmodule // postdiv_chk
bind synth_post_divider_outputs postdiv_chk postdiv_chk_inst (.CLK(CLK), .SRST(SRST), .CE(CE),
	.SYN_TICK(SYN_TICK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
	.REG_RDATA(REG_RDATA), .OUT_A(OUT_A), .OUT_B(OUT_B));
`default_nettype wire

/* verif/synth_post_divider_outputs_tb.sv */
// Self-checking bench for the post-divider block.
// Assumes ticks and sibling clocks are made here in step with CLK.
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module synth_post_divider_outputs_tb import postdiv_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        CLK = 1'b0, SRST = 1'b1, SYN_TICK = 1'b0, BASE2_TICK = 1'b0, REG_WR = 1'b0;
	logic        CLK_C = 1'b0, CLK_D = 1'b1, OUT_A, OUT_B, sel_b = 1'b0, inv = 1'b0, o;
	logic [6:0]  REG_ADDR = 7'h00;
	logic [7:0]  REG_WDATA = 8'h00, REG_RDATA;
	logic [15:0] rnd = 16'h9ff0;
	logic        CE = 1'b1;
	logic [9:0]  frz;
	logic [23:0] cfg [2];
	int          cnt [4], ph, cyc, failures, checked;
	synth_post_divider_outputs synth_post_divider_outputs_inst (.CLK(CLK), .SRST(SRST), .CE(CE),
		.SYN_TICK(SYN_TICK), .BASE2_TICK(BASE2_TICK), .CLK_C(CLK_C), .CLK_D(CLK_D),
		.REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RDATA(REG_RDATA),
		.OUT_A(OUT_A), .OUT_B(OUT_B));
	always #4 CLK = ~CLK;
	assign o = (sel_b ? OUT_B : OUT_A) ^ inv;
	// ----
	// Stimulus and tick counts
	// ----
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	always @(posedge CLK) begin
		#1;
		rnd = lfsr(rnd);
		SYN_TICK = rnd[0];
		BASE2_TICK = rnd[5];
		ph = (ph + 1) % 4;
		if (ph == 0) begin
			CLK_C = ~CLK_C;
			CLK_D = ~CLK_C;
		end
		cnt[0] += SYN_TICK;
		cnt[1] += BASE2_TICK;
		cnt[2] += (ph == 0 && CLK_C);
		cnt[3] += (ph == 0 && CLK_D);
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge CLK) #1;
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		@(posedge CLK) #1;
		REG_WR = 1'b0;
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		@(posedge CLK) #1;
		REG_ADDR = a;
		@(posedge CLK) #1;
		`CHK("rdata", e, REG_RDATA)
	endtask
	// A word only counts once all three bytes are in.
	task automatic run(input bit b, input logic [23:0] w);
		int s, p, h, t0, t1;
		logic lv, fr;
		logic [6:0] a;
		a = b ? 7'h03 : 7'h00;
		wr(a + 7'h02, w[23:16]);
		wr(a, w[7:0]);
		rd(a, cfg[b][7:0]);
		wr(a + 7'h01, w[15:8]);
		cfg[b] = w;
		for (int i = 0; i < 3; i++) rd(a + 7'(i), w[8 * i +: 8]);
		s = 0;
		p = w;
		fr = 1'b0;
		if (w[23:20] == MODE_SPECIAL) begin
			s = (w[17:16] == (b ? LF_SRC_B : LF_SRC_A)) ? 1 : w[17:16];
			p = w[15:0];
			fr = s > 1;
		end
		h = fr ? 1 : p / 2;
		sel_b = b;
		inv = fr & w[18];
		repeat (20) @(posedge CLK);
		@(posedge o) t0 = cnt[s];
		lv = s == 3 ? CLK_D : CLK_C;
		@(negedge o) t1 = cnt[s];
		@(posedge o) `CHK("period", p, cnt[s] - t0)
		`CHK("active", h, t1 - t0)
		if (fr) `CHK("edge", w[19], lv)
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (20) @(posedge CLK);
		#1 SRST = 1'b0;
		repeat (30) @(posedge CLK);
		rd(7'h06, 8'h00);
		wr(7'h7f, 8'h01);
		rd(7'h7f, 8'h01);
		for (int i = 0; i < 6; i++) rd(7'(i), i % 3 ? 8'h00 : DIV_CFG_RESET[7:0]);
		CE = 1'b0;
		frz = {OUT_A, OUT_B, REG_RDATA};
		repeat (6) @(posedge CLK);
		#1 `CHK("freeze", frz, {OUT_A, OUT_B, REG_RDATA})
		CE = 1'b1;
		cfg = '{DIV_CFG_RESET, DIV_CFG_RESET};
		for (int k = 0; k < 4; k++) run(k[0], {21'h000000, rnd[2:0]} + 24'h000002);
		run(1'b0, 24'hf00004);
		run(1'b1, 24'hf10003);
		run(1'b0, 24'hf20003);
		run(1'b1, 24'hfb0002);
		run(1'b0, 24'hf60003);
		run(1'b1, 24'hfe0004);
		stop_test();
	end
	task automatic stop_test();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
endmodule // synth_post_divider_outputs_tb
`default_nettype wire
